// ===== core/sensor_cfg_defs.svh
// Named offsets, field positions and reset values of the config bank.
// Assumes inclusion by bare name from the design, the checker and the bench.
`ifndef SENSOR_CFG_DEFS_SVH
`define SENSOR_CFG_DEFS_SVH
// Register indices, byte address is four times the index
`define IX_ROW_WIN9 7'h44
`define IX_GAIN_EE 7'h48
`define IX_GAIN_EO 7'h49
`define IX_GAIN_OE 7'h4a
`define IX_GAIN_OO 7'h4b
`define IX_BLACK 7'h4c
`define IX_AGAIN 7'h4e
`define IX_TRAIN 7'h4f
`define IX_TEST 7'h51
`define IX_FUSE_CMD 7'h61
`define IX_FUSE_ADR 7'h62
`define IX_FUSE_DAT 7'h65
`define IX_TS_CTL 7'h67
`define IX_TS_RES 7'h68
`define IX_PLL1 7'h6a
// Row window field positions
`define RW_CNT_HI 12
`define RW_CNT_LO 0
`define RW_START_HI 25
`define RW_START_LO 13
`define RW_SUB_HI 28
`define RW_SUB_LO 26
// Thermal control field positions
`define TS_PWR_BIT 0
`define TS_RST_BIT 1
`define TS_TRIM_HI 7
`define TS_TRIM_LO 2
// Reset values
`define RST_ROW_WIN9 29'h0
`define RST_GAIN 8'h0f
`define RST_BLACK 14'h0020
`define RST_AGAIN 8'h00
`define RST_TRAIN 14'h0055
`define RST_TEST 3'h0
`define RST_TS_TRIM 6'h20
// Test select encodings
`define TEST_NORMAL 3'h0
`define TEST_TRAIN 3'h1
`define TEST_GRAD 3'h2
`define TEST_LFSR 3'h3
// LFSR seed
`define LFSR_SEED 14'h0001
`endif

// ===== core/sensor_cfg_pkg.sv
// Types shared by the configuration bank.
// Assumes sensor_cfg_defs.svh for widths of reset values.
package sensor_cfg_pkg;
    // Frame-synchronised settings
    typedef struct packed {
        logic [2:0] row_subsample_exponent;
        logic [12:0] row_start;
        logic [12:0] row_count;
        logic [7:0] gain_even_row_even_col;
        logic [7:0] gain_even_row_odd_col;
        logic [7:0] gain_odd_row_even_col;
        logic [7:0] gain_odd_row_odd_col;
        logic [13:0] black_level_target;
        logic [7:0] analog_gain_code;
    } sync_cfg_t;
    // Thermal sensor controls
    typedef struct packed {
        logic [5:0] thermal_sense_trim;
        logic thermal_sense_reset_release;
        logic thermal_sense_power;
    } thermal_ctl_t;
    // Lane content source
    typedef enum logic [1:0] {
        SRC_IMAGE = 2'b00,
        SRC_TRAIN = 2'b01,
        SRC_GRAD = 2'b10,
        SRC_LFSR = 2'b11
    } lane_src_t;
    // Bus handshake state
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_state_t;
endpackage

// ===== core/sensor_config_regs_rowwin_gain_test.sv
// Config bank: row window 9, digital gains, black level, analog gain,
// link pattern, lane test select, fuse access, thermal and First_pll_on.
// Assumes an Avalon-MM master on i_clk and a one-cycle frame pulse.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "sensor_cfg_defs.svh"

// What this block does
// - Row window count in bits 12:0
// - Window first row address in bits 25:13
// - Subsample exponent in bits 28:26
// - Parity-selected digital gain, default fifteen
// - Black level target, default thirty-two
// - Training word driven on lanes, default 85
// - Test select picks lane content
// - Thermal power bit, default down
// - Thermal reset release bit, default held
// - Thermal trim field, default thirty-two
// - First_pll_on bit, default off
module sensor_config_regs_rowwin_gain_test #(
    parameter int PIX_W = 14,
    parameter int GAIN_SHIFT = 4
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Avalon-MM slave
    input wire logic [8:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Frame timing
    input wire logic i_frame_start,
    // Pixel stream in
    input wire logic i_pix_valid,
    input wire logic [PIX_W-1:0] i_pix_data,
    input wire logic i_pix_row_odd,
    input wire logic i_pix_col_odd,
    // Lane data out
    output logic o_lane_valid,
    output logic [PIX_W-1:0] o_lane_data,
    // Active frame settings
    output sensor_cfg_pkg::sync_cfg_t o_cfg,
    // Fuse memory
    output logic [3:0] o_fuse_cmd,
    output logic [6:0] o_fuse_addr,
    input wire logic [15:0] i_fuse_rdata,
    // Thermal sensor
    output sensor_cfg_pkg::thermal_ctl_t o_thermal,
    input wire logic [9:0] i_thermal_result,
    // PLL
    output logic o_first_pll_on
);

    //--------------------------------------------------------------
    // Elaboration checks
    //--------------------------------------------------------------
    if (PIX_W != 14 || GAIN_SHIFT < 0 || GAIN_SHIFT > 8)
    begin : g_chk
        $error("PIX_W must be 14 and GAIN_SHIFT within 0 to 8");
    end

    //--------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------
    // Word address match against a register index
    function automatic logic hit(input logic [8:0] a, input logic [6:0] ix);
        hit = (a == {ix, 2'b00});
    endfunction

    // Byte-lane merge, lane 0 is the lowest byte address
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        merge = r;
    endfunction

    //--------------------------------------------------------------
    // Bus handshake
    //--------------------------------------------------------------
    sensor_cfg_pkg::bus_state_t bus_state;
    logic req; // Request pending
    logic wr_take; // Write commits this cycle

    assign req = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & (bus_state == sensor_cfg_pkg::BUS_IDLE);
    assign wr_take = i_avs_write & (bus_state == sensor_cfg_pkg::BUS_ACK);

    // One wait cycle, then release for a cycle
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            bus_state <= sensor_cfg_pkg::BUS_IDLE;
        end
        else
        begin
            case (bus_state)
                sensor_cfg_pkg::BUS_IDLE:
                    if (req)
                        bus_state <= sensor_cfg_pkg::BUS_ACK;
                sensor_cfg_pkg::BUS_ACK:
                    bus_state <= sensor_cfg_pkg::BUS_IDLE;
                default:
                    bus_state <= sensor_cfg_pkg::BUS_IDLE;
            endcase
        end
    end

    //--------------------------------------------------------------
    // Software-visible registers
    //--------------------------------------------------------------
    logic [28:0] row_window_9; // Pending window setting
    logic [7:0] gain_ee; // Pending gains
    logic [7:0] gain_eo;
    logic [7:0] gain_oe;
    logic [7:0] gain_oo;
    logic [13:0] black_level_target; // Pending target
    logic [7:0] analog_gain_code; // Pending analog code
    logic [13:0] link_sync_pattern; // Training word
    logic [2:0] output_test_select; // Lane content select
    logic [3:0] fuse_cmd;
    logic [6:0] fuse_addr;
    logic [15:0] fuse_rdata; // Captured fuse data
    logic [9:0] thermal_res; // Captured thermal result
    sensor_cfg_pkg::thermal_ctl_t thermal;
    logic first_pll_on;
    logic [31:0] wd; // Merged write word
    logic [31:0] o_avs_readdata_n; // Current word of addressed register

    // Merge against the addressed register's current word
    always_comb
    begin
        wd = merge(o_avs_readdata_n, i_avs_writedata, i_avs_byteenable);
    end

    // Synced settings, written any time, applied at frame start
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            row_window_9 <= `RST_ROW_WIN9;
            gain_ee <= `RST_GAIN;
            gain_eo <= `RST_GAIN;
            gain_oe <= `RST_GAIN;
            gain_oo <= `RST_GAIN;
            black_level_target <= `RST_BLACK;
            analog_gain_code <= `RST_AGAIN;
        end
        else if (wr_take)
        begin
            // Merged word, only enabled bytes change, low byte at lowest address
            if (hit(i_avs_address, `IX_ROW_WIN9))
                row_window_9 <= wd[28:0];
            if (hit(i_avs_address, `IX_GAIN_EE))
                gain_ee <= wd[7:0];
            if (hit(i_avs_address, `IX_GAIN_EO))
                gain_eo <= wd[7:0];
            if (hit(i_avs_address, `IX_GAIN_OE))
                gain_oe <= wd[7:0];
            if (hit(i_avs_address, `IX_GAIN_OO))
                gain_oo <= wd[7:0];
            if (hit(i_avs_address, `IX_BLACK))
                black_level_target <= wd[13:0];
            // Code stored as given; valid codes are software's task
            if (hit(i_avs_address, `IX_AGAIN))
                analog_gain_code <= wd[7:0];
        end
    end

    // Direct settings, effective at once
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            link_sync_pattern <= `RST_TRAIN;
            output_test_select <= `RST_TEST;
            fuse_cmd <= '0;
            fuse_addr <= '0;
            thermal <= '{`RST_TS_TRIM, 1'b0, 1'b0};
            first_pll_on <= 1'b0;
        end
        else if (wr_take)
        begin
            if (hit(i_avs_address, `IX_TRAIN))
                link_sync_pattern <= wd[13:0];
            if (hit(i_avs_address, `IX_TEST))
                output_test_select <= wd[2:0];
            if (hit(i_avs_address, `IX_FUSE_CMD))
                fuse_cmd <= wd[3:0];
            if (hit(i_avs_address, `IX_FUSE_ADR))
                fuse_addr <= wd[6:0];
            if (hit(i_avs_address, `IX_TS_CTL))
            begin
                thermal.thermal_sense_power <= wd[`TS_PWR_BIT];
                thermal.thermal_sense_reset_release <= wd[`TS_RST_BIT];
                thermal.thermal_sense_trim <= wd[`TS_TRIM_HI:`TS_TRIM_LO];
            end
            if (hit(i_avs_address, `IX_PLL1))
                first_pll_on <= wd[0];
        end
    end

    // Read-only sources sampled every cycle, writes have no path here
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            fuse_rdata <= '0;
            thermal_res <= '0;
        end
        else
        begin
            fuse_rdata <= i_fuse_rdata;
            thermal_res <= i_thermal_result;
        end
    end

    //--------------------------------------------------------------
    // Read mux
    //--------------------------------------------------------------
    // Unmapped and reserved bits read as zero
    always_comb
    begin
        o_avs_readdata_n = '0;
        if (hit(i_avs_address, `IX_ROW_WIN9))
            o_avs_readdata_n = {3'h0, row_window_9};
        if (hit(i_avs_address, `IX_GAIN_EE))
            o_avs_readdata_n = {24'h0, gain_ee};
        if (hit(i_avs_address, `IX_GAIN_EO))
            o_avs_readdata_n = {24'h0, gain_eo};
        if (hit(i_avs_address, `IX_GAIN_OE))
            o_avs_readdata_n = {24'h0, gain_oe};
        if (hit(i_avs_address, `IX_GAIN_OO))
            o_avs_readdata_n = {24'h0, gain_oo};
        if (hit(i_avs_address, `IX_BLACK))
            o_avs_readdata_n = {18'h0, black_level_target};
        if (hit(i_avs_address, `IX_AGAIN))
            o_avs_readdata_n = {24'h0, analog_gain_code};
        if (hit(i_avs_address, `IX_TRAIN))
            o_avs_readdata_n = {18'h0, link_sync_pattern};
        if (hit(i_avs_address, `IX_TEST))
            o_avs_readdata_n = {29'h0, output_test_select};
        if (hit(i_avs_address, `IX_FUSE_CMD))
            o_avs_readdata_n = {28'h0, fuse_cmd};
        if (hit(i_avs_address, `IX_FUSE_ADR))
            o_avs_readdata_n = {25'h0, fuse_addr};
        if (hit(i_avs_address, `IX_FUSE_DAT))
            o_avs_readdata_n = {16'h0, fuse_rdata};
        if (hit(i_avs_address, `IX_TS_CTL))
            o_avs_readdata_n = {24'h0, thermal};
        if (hit(i_avs_address, `IX_TS_RES))
            o_avs_readdata_n = {22'h0, thermal_res};
        if (hit(i_avs_address, `IX_PLL1))
            o_avs_readdata_n = {31'h0, first_pll_on};
    end

    // Read data captured in the wait cycle, valid at the release
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_avs_readdata <= '0;
        else if (i_avs_read && bus_state == sensor_cfg_pkg::BUS_IDLE)
            o_avs_readdata <= o_avs_readdata_n;
    end

    //--------------------------------------------------------------
    // Frame-boundary update of synced settings
    //--------------------------------------------------------------
    // Whole set moves together so no frame sees a partial update
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_cfg <= '{3'(`RST_ROW_WIN9 >> `RW_SUB_LO), 13'(`RST_ROW_WIN9 >> `RW_START_LO),
                       13'(`RST_ROW_WIN9), `RST_GAIN, `RST_GAIN, `RST_GAIN, `RST_GAIN,
                       `RST_BLACK, `RST_AGAIN};
        end
        else if (i_frame_start)
        begin
            o_cfg.row_count <= row_window_9[`RW_CNT_HI:`RW_CNT_LO];
            o_cfg.row_start <= row_window_9[`RW_START_HI:`RW_START_LO];
            o_cfg.row_subsample_exponent <= row_window_9[`RW_SUB_HI:`RW_SUB_LO];
            o_cfg.gain_even_row_even_col <= gain_ee;
            o_cfg.gain_even_row_odd_col <= gain_eo;
            o_cfg.gain_odd_row_even_col <= gain_oe;
            o_cfg.gain_odd_row_odd_col <= gain_oo;
            o_cfg.black_level_target <= black_level_target;
            o_cfg.analog_gain_code <= analog_gain_code;
        end
    end

    //--------------------------------------------------------------
    // Pixel gain
    //--------------------------------------------------------------
    logic [7:0] sel_gain; // Gain for this pixel's parity
    logic [PIX_W+7:0] prod; // Scaled product
    logic [PIX_W-1:0] gained; // Saturated result

    // Parity picks one of four active gains
    always_comb
    begin
        case ({i_pix_row_odd, i_pix_col_odd})
            2'b00: sel_gain = o_cfg.gain_even_row_even_col;
            2'b01: sel_gain = o_cfg.gain_even_row_odd_col;
            2'b10: sel_gain = o_cfg.gain_odd_row_even_col;
            2'b11: sel_gain = o_cfg.gain_odd_row_odd_col;
            default: sel_gain = o_cfg.gain_even_row_even_col;
        endcase
        prod = (i_pix_data * sel_gain) >> GAIN_SHIFT;
        gained = (|prod[PIX_W+7:PIX_W]) ? '1 : prod[PIX_W-1:0]; // Saturate at full scale
    end

    //--------------------------------------------------------------
    // Test patterns
    //--------------------------------------------------------------
    logic [PIX_W-1:0] grad; // Gradient counter
    logic [PIX_W-1:0] lfsr; // Pseudo-random word
    sensor_cfg_pkg::lane_src_t src;

    // Decode test select into a lane source
    always_comb
    begin
        case (output_test_select)
            `TEST_NORMAL: src = sensor_cfg_pkg::SRC_IMAGE;
            `TEST_TRAIN: src = sensor_cfg_pkg::SRC_TRAIN;
            `TEST_GRAD: src = sensor_cfg_pkg::SRC_GRAD;
            `TEST_LFSR: src = sensor_cfg_pkg::SRC_LFSR;
            default: src = sensor_cfg_pkg::SRC_TRAIN;
        endcase
    end

    // Pattern generators restart each frame
    always_ff @(posedge i_clk)
    begin
        if (i_rst || i_frame_start)
        begin
            grad <= '0;
            lfsr <= `LFSR_SEED;
        end
        else
        begin
            grad <= grad + 1'b1;
            lfsr <= {lfsr[12:0], lfsr[13] ^ lfsr[4] ^ lfsr[2] ^ lfsr[0]};
        end
    end

    //--------------------------------------------------------------
    // Lane output
    //--------------------------------------------------------------
    // Image only when a pixel arrives; patterns run every cycle
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_lane_valid <= 1'b0;
            o_lane_data <= '0;
        end
        else
        begin
            // Image lanes follow the pixel strobe, patterns are always valid
            o_lane_valid <= (src != sensor_cfg_pkg::SRC_IMAGE) || i_pix_valid;
            case (src)
                sensor_cfg_pkg::SRC_IMAGE:
                    o_lane_data <= i_pix_valid ? gained : link_sync_pattern;
                sensor_cfg_pkg::SRC_TRAIN:
                    o_lane_data <= link_sync_pattern;
                sensor_cfg_pkg::SRC_GRAD:
                    o_lane_data <= grad;
                sensor_cfg_pkg::SRC_LFSR:
                    o_lane_data <= lfsr;
                default:
                    o_lane_data <= '0;
            endcase
        end
    end

    //--------------------------------------------------------------
    // Side outputs
    //--------------------------------------------------------------
    assign o_fuse_cmd = fuse_cmd;
    assign o_fuse_addr = fuse_addr;
    assign o_thermal = thermal;
    assign o_first_pll_on = first_pll_on;

endmodule

// ===== verif/sensor_cfg_properties.sv
// Checker for the config bank: bus timing, frame sync and lane modes.
// Assumes binding onto the bank top module, single clock domain.
`timescale 1ns/1ps
`include "sensor_cfg_defs.svh"
module sensor_cfg_checker #(
    parameter int PIX_W = 14
) (
    // Clock, reset and bus
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [8:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    input wire logic o_avs_waitrequest,
    // Frame, lanes and control outputs
    input wire logic i_frame_start,
    input wire logic i_pix_valid,
    input wire logic o_lane_valid,
    input wire logic [PIX_W-1:0] o_lane_data,
    input wire sensor_cfg_pkg::sync_cfg_t o_cfg,
    input wire logic [3:0] o_fuse_cmd,
    input wire sensor_cfg_pkg::thermal_ctl_t o_thermal,
    input wire logic o_first_pll_on
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Full-word write commit
    logic wr_go;
    logic [6:0] wr_ix;
    assign wr_go = i_avs_write && !o_avs_waitrequest && (i_avs_byteenable == 4'hf);
    assign wr_ix = i_avs_address[8:2];
    // Shadows of lane mode, training word and one gain
    logic [2:0] h_mode;
    logic [13:0] h_train;
    logic [7:0] h_gain;
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            h_mode <= `RST_TEST;
            h_train <= `RST_TRAIN;
            h_gain <= `RST_GAIN;
        end
        else if (wr_go)
        begin
            if (wr_ix == `IX_TEST) h_mode <= i_avs_writedata[2:0];
            if (wr_ix == `IX_TRAIN) h_train <= i_avs_writedata[13:0];
            if (wr_ix == `IX_GAIN_EE) h_gain <= i_avs_writedata[7:0];
        end
    end
    AST_ONE_WAIT: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("bus answer late");
    AST_WAIT_FIRST: assert property ($rose(i_avs_read || i_avs_write)
        |-> o_avs_waitrequest) else $error("bus answered at once");
    AST_PLL: assert property (wr_go && wr_ix == `IX_PLL1
        |=> o_first_pll_on == $past(i_avs_writedata[0])) else $error("pll bit wrong");
    AST_THERM: assert property (wr_go && wr_ix == `IX_TS_CTL
        |=> o_thermal == $past(i_avs_writedata[7:0])) else $error("thermal wrong");
    AST_FUSE: assert property (wr_go && wr_ix == `IX_FUSE_CMD
        |=> o_fuse_cmd == $past(i_avs_writedata[3:0])) else $error("fuse cmd wrong");
    AST_CFG_HOLD: assert property (!i_frame_start |=> $stable(o_cfg))
        else $error("settings moved mid frame");
    AST_CFG_GAIN: assert property (i_frame_start
        |=> o_cfg.gain_even_row_even_col == $past(h_gain)) else $error("gain not loaded");
    AST_TRAIN_LANE: assert property ($past(h_mode) inside {3'h1, [3'h4:3'h7]}
        |-> o_lane_data == $past(h_train)) else $error("training word missing");
    AST_LANE_QUIET: assert property ($past(h_mode) == 3'h0 && !$past(i_pix_valid)
        |-> !o_lane_valid) else $error("lane valid without pixel");
endmodule
bind sensor_config_regs_rowwin_gain_test sensor_cfg_checker #(.PIX_W(PIX_W)) i_chk (
    .i_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_byteenable,
    .i_avs_writedata, .o_avs_waitrequest, .i_frame_start, .i_pix_valid, .o_lane_valid,
    .o_lane_data, .o_cfg, .o_fuse_cmd, .o_thermal, .o_first_pll_on);

// ===== verif/sensor_config_regs_rowwin_gain_test_tb.sv
// Self-checking bench for the config bank.
// Assumes the bank top, its package and the defs header on the path.
`timescale 1ns/1ps
`include "sensor_cfg_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module sensor_config_regs_rowwin_gain_test_tb;
    // ------------------------------------------------------------
    // Signals and register table
    // ------------------------------------------------------------
    localparam int NREG = 13;
    localparam int GS = 4;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [8:0] i_avs_address = '0;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [3:0] i_avs_byteenable = '0;
    logic [31:0] i_avs_writedata = '0;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic i_frame_start = 1'b0;
    logic i_pix_valid = 1'b0;
    logic [13:0] i_pix_data = '0;
    logic i_pix_row_odd = 1'b0;
    logic i_pix_col_odd = 1'b0;
    logic o_lane_valid;
    logic [13:0] o_lane_data;
    sensor_cfg_pkg::sync_cfg_t o_cfg;
    sensor_cfg_pkg::sync_cfg_t exp_c;
    logic [3:0] o_fuse_cmd;
    logic [6:0] o_fuse_addr;
    logic [15:0] i_fuse_rdata = '0;
    sensor_cfg_pkg::thermal_ctl_t o_thermal;
    logic [9:0] i_thermal_result = '0;
    logic o_first_pll_on;
    int errors = 0;
    int checked = 0;
    logic [31:0] rd;
    logic [31:0] wv;
    logic [13:0] px;
    logic [6:0] ix_t [NREG] = '{`IX_ROW_WIN9, `IX_GAIN_EE, `IX_GAIN_EO, `IX_GAIN_OE,
        `IX_GAIN_OO, `IX_BLACK, `IX_AGAIN, `IX_TRAIN, `IX_TEST, `IX_FUSE_CMD,
        `IX_FUSE_ADR, `IX_TS_CTL, `IX_PLL1};
    logic [31:0] msk_t [NREG] = '{32'h1fffffff, 32'hff, 32'hff, 32'hff, 32'hff, 32'h3fff,
        32'hff, 32'h3fff, 32'h7, 32'hf, 32'h7f, 32'hff, 32'h1};
    logic [31:0] rst_t [NREG] = '{32'h0, 32'hf, 32'hf, 32'hf, 32'hf, 32'h20, 32'h0,
        32'h55, 32'h0, 32'h0, 32'h0, 32'h80, 32'h0};
    logic [31:0] ag_t [6] = '{32'hff, 32'hf3, 32'hf1, 32'hdf, 32'hd3, 32'hd1};
    logic [31:0] cur [NREG];
    // Clock at 100 MHz
    always #5 i_clk = ~i_clk;
    sensor_config_regs_rowwin_gain_test #(.PIX_W(14), .GAIN_SHIFT(GS)) i_dut (.*);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // One bus access, held until waitrequest low
    task automatic bus(input logic wr, input logic [6:0] ix, input logic [31:0] wd,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge i_clk);
        i_avs_address <= {ix, 2'b00};
        i_avs_write <= wr;
        i_avs_read <= !wr;
        i_avs_writedata <= wd;
        i_avs_byteenable <= be;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_avs_waitrequest !== 1'b0 && n < 20);
        rd = o_avs_readdata;
        if (n >= 20) errors++;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask
    // Read and compare
    task automatic rd_chk(input logic [6:0] ix, input logic [31:0] e);
        bus(1'b0, ix, 32'h0, 4'h0);
        `CHK(rd, e)
    endtask
    // One frame start pulse, outputs settled on return
    task automatic frame();
        @(posedge i_clk);
        i_frame_start <= 1'b1;
        @(posedge i_clk);
        i_frame_start <= 1'b0;
        #1;
    endtask
    // Active settings expected from the register copy
    function automatic sensor_cfg_pkg::sync_cfg_t cfg_of();
        cfg_of = '{cur[0][28:26], cur[0][25:13], cur[0][12:0], cur[1][7:0], cur[2][7:0],
                   cur[3][7:0], cur[4][7:0], cur[5][13:0], cur[6][7:0]};
    endfunction
    // Gained and saturated pixel
    function automatic logic [13:0] gained(input logic [13:0] p, input logic [7:0] g);
        logic [21:0] t;
        t = (22'(p) * 22'(g)) >> GS;
        gained = (t > 22'h3fff) ? 14'h3fff : t[13:0];
    endfunction
    // Closing verdict
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #500000;
        errors++;
        end_sim();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(25499));
        cur = rst_t;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        // Reset values of registers and outputs
        for (int k = 0; k < NREG; k++) rd_chk(ix_t[k], rst_t[k]);
        `CHK(o_cfg, cfg_of())
        `CHK(o_thermal, 8'h80)
        `CHK(o_first_pll_on, 1'b0)
        $display("test reset done");
        // Random then all-ones writes; synced fields wait for frame
        for (int p = 0; p < 2; p++)
        begin
            exp_c = cfg_of();
            for (int k = 0; k < NREG; k++)
            begin
                wv = p ? 32'hffffffff : $urandom();
                bus(1'b1, ix_t[k], wv, 4'hf);
                cur[k] = wv & msk_t[k];
            end
            `CHK(o_cfg, exp_c)
            frame();
            `CHK(o_cfg, cfg_of())
            for (int k = 0; k < NREG; k++) rd_chk(ix_t[k], cur[k]);
            `CHK(o_thermal, cur[11][7:0])
            `CHK(o_first_pll_on, cur[12][0])
            `CHK({o_fuse_addr, o_fuse_cmd}, {cur[10][6:0], cur[9][3:0]})
        end
        $display("test write done");
        // Read-only, unmapped and single-lane writes
        @(posedge i_clk);
        i_fuse_rdata <= 16'($urandom());
        i_thermal_result <= 10'($urandom());
        bus(1'b1, `IX_FUSE_DAT, 32'hffffffff, 4'hf);
        bus(1'b1, `IX_TS_RES, 32'hffffffff, 4'hf);
        bus(1'b1, 7'h50, 32'hffffffff, 4'hf);
        rd_chk(`IX_FUSE_DAT, {16'h0, i_fuse_rdata});
        rd_chk(`IX_TS_RES, {22'h0, i_thermal_result});
        rd_chk(7'h50, 32'h0);
        wv = $urandom();
        bus(1'b1, `IX_ROW_WIN9, wv, 4'b0001);
        cur[0] = {cur[0][31:8], wv[7:0]};
        frame();
        rd_chk(`IX_ROW_WIN9, cur[0]);
        $display("test access done");
        // Normal mode: gain picked by row and column parity
        bus(1'b1, `IX_TEST, 32'h0, 4'hf);
        for (int k = 1; k < 5; k++)
        begin
            cur[k] = 32'($urandom_range(255, 1));
            bus(1'b1, ix_t[k], cur[k], 4'hf);
        end
        cur[6] = ag_t[$urandom_range(5, 0)];
        bus(1'b1, `IX_AGAIN, cur[6], 4'hf);
        frame();
        `CHK(o_cfg, cfg_of())
        for (int p = 0; p < 8; p++)
        begin
            px = (p > 3) ? 14'h3fff : 14'($urandom());
            @(posedge i_clk);
            i_pix_valid <= 1'b1;
            i_pix_data <= px;
            {i_pix_row_odd, i_pix_col_odd} <= 2'(p);
            @(posedge i_clk);
            i_pix_valid <= 1'b0;
            #1;
            `CHK({o_lane_valid, o_lane_data}, {1'b1, gained(px, cur[1 + p % 4][7:0])})
        end
        // Lane test codes 1 to 7; training word where it applies
        for (int m = 1; m < 8; m++)
        begin
            cur[7] = 32'($urandom_range(16383, 0));
            bus(1'b1, `IX_TRAIN, cur[7], 4'hf);
            bus(1'b1, `IX_TEST, m, 4'hf);
            repeat (2) @(posedge i_clk);
            #1;
            if (m == 1 || m > 3) `CHK(o_lane_data, cur[7][13:0])
            if (m == 2 || m == 3)
            begin
                frame();
                repeat (2) @(posedge i_clk);
                #1;
                `CHK(o_lane_data, (m == 2) ? 14'h0001 : 14'h0003)
            end
        end
        $display("test lanes done");
        end_sim();
    end
endmodule
